// >>> src/dsio_defines.svh
`ifndef DSIO_DEFINES_SVH
`define DSIO_DEFINES_SVH

`define DSIO_DATA_W      36
`define DSIO_BYTE_W      9
`define DSIO_ADDR_W      8
`define DSIO_MEM_DEPTH   256
`define DSIO_BURST_LEN   2
`define DSIO_BUF_DEPTH   2
`define DSIO_DQ_RST      36'h000000000

`endif

// >>> src/dsio_pkg.sv
package dsio_pkg;
  typedef enum logic [1:0] {DSIO_IDLE, DSIO_WR_B0, DSIO_WR_B1} dsio_wr_e;
  typedef enum logic [1:0] {DSIO_RD_IDLE, DSIO_RD_B0, DSIO_RD_B1} dsio_rd_e;
endpackage

// >>> src/dsio_buf_if.sv
`timescale 1ns/10ps
`include "dsio_defines.svh"
interface dsio_buf_if;
  logic                    in_valid;
  logic                    in_ready;
  logic [`DSIO_DATA_W-1:0] in_data;
  logic                    out_valid;
  logic                    out_ready;
  logic [`DSIO_DATA_W-1:0] out_data;
  modport fill  (output in_valid, output in_data, input in_ready,
                 input out_valid, input out_data, output out_ready);
  modport store (input in_valid, input in_data, output in_ready,
                 output out_valid, output out_data, input out_ready);
endinterface

// >>> src/dsio_skid_buf.sv
`timescale 1ns/10ps
`include "dsio_defines.svh"
module dsio_skid_buf
  import dsio_pkg::*;
(
  // clock
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic clk_en,
  // stream
  dsio_buf_if.store bus
);
  logic [`DSIO_DATA_W-1:0] mem [`DSIO_BUF_DEPTH];
  logic                    wr_ptr;
  logic                    rd_ptr;
  logic [1:0]              count;
  wire push = bus.in_valid && bus.in_ready;
  wire pop  = bus.out_valid && bus.out_ready;

  assign bus.in_ready  = (count != 2'h2);
  assign bus.out_valid = (count != 2'h0);
  assign bus.out_data  = mem[rd_ptr];

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else if (clk_en) begin
      if (push) begin
        mem[wr_ptr] <= bus.in_data;
        wr_ptr      <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// >>> src/dsio_sram_port.sv
`timescale 1ns/10ps
`include "dsio_defines.svh"
// Summary of operation
// [R01] a write starts on load low and select low, data follows at next k rise and k_n rise.
// [R02] a read starts on load low and select high, first word then second word one edge later.
// [R03] with load high no access starts and the data outputs are not driven; reset deselects.
// [R04] while the input clocks stand still the data outputs hold their previous state.
// [R05] the first burst word uses the latched address and the second the next address.
// [R06] write data is taken on both input clock rises, read data launched on output clock rises.
// [R07] the controller should park all clocks high when it stops them.
// [R08] in the 18-bit organisation two active-low selects gate bits 8:0 and 17:9 per beat.
// [R09] with every select high on a beat nothing is written for that beat.
// [R10] in the 36-bit organisation four selects gate the four nine-bit bytes per beat.
// [R11] each beat's selects apply only to the word written on that beat.
// [R12] the data width is a parameter of 18 or 36, with one select per nine bits.
module dsio_sram_port
  import dsio_pkg::*;
#(
  parameter int DATA_W = `DSIO_DATA_W
)(
  // core clock
  input  wire logic                          sys_clk,
  input  wire logic                          srst,
  input  wire logic                          clk_en,
  // link clock and controls
  input  wire logic                          link_clk,
  input  wire logic                          access_load_n,
  input  wire logic                          rd_wr_sel,
  input  wire logic [`DSIO_ADDR_W-1:0]       addr,
  input  wire logic [DATA_W-1:0]             wr_data,
  input  wire logic [DATA_W/`DSIO_BYTE_W-1:0] byte_write_sel_n,
  // read data pins
  output logic      [DATA_W-1:0]             rd_data,
  output logic                               rd_data_oe_n
);
  // [R12] select count from width
  localparam int NB = DATA_W / `DSIO_BYTE_W;
  localparam int BW = `DSIO_BYTE_W;

  // link-side capture: beat 0 on k rise, beat 1 on the next rise (k_n modelled as the
  // following link edge since the link runs single-edge here)
  logic [`DSIO_ADDR_W-1:0] lk_addr;
  logic [DATA_W-1:0]       lk_d0;
  logic [NB-1:0]           lk_m0;
  logic [DATA_W-1:0]       lk_d1;
  logic [NB-1:0]           lk_m1;
  logic                    lk_wr;
  logic                    lk_rd;
  logic                    lk_tog;
  dsio_wr_e                lk_st;
  logic [`DSIO_ADDR_W-1:0] lk_rd_addr;

  // reset and enable come from the core domain, so each passes two link flops;
  // a command that arrives while the core is frozen is dropped
  logic                    lk_rst_s1;
  logic                    lk_rst;
  logic                    lk_en_s1;
  logic                    lk_en;
  always_ff @(posedge link_clk) begin
    lk_rst_s1 <= srst;
    lk_rst    <= lk_rst_s1;
    lk_en_s1  <= clk_en;
    lk_en     <= lk_en_s1;
  end

  always_ff @(posedge link_clk) begin
    if (lk_rst) begin
      lk_st  <= DSIO_IDLE;
      lk_tog <= 1'b0;
      lk_wr  <= 1'b0;
      lk_rd  <= 1'b0;
    end else if (lk_en) begin
      case (lk_st)
        DSIO_IDLE: begin
          // [R01] [R02] [R03] command decode
          if (!access_load_n && !rd_wr_sel) begin
            lk_addr <= addr;
            lk_st   <= DSIO_WR_B0;
          end else if (!access_load_n && rd_wr_sel) begin
            lk_rd_addr <= addr;
            lk_rd      <= 1'b1;
            lk_wr      <= 1'b0;
            lk_tog     <= ~lk_tog;
          end
        end
        DSIO_WR_B0: begin
          // [R06] [R11] beat 0 data with its own selects
          lk_d0 <= wr_data;
          lk_m0 <= byte_write_sel_n;
          lk_st <= DSIO_WR_B1;
        end
        DSIO_WR_B1: begin
          lk_d1  <= wr_data;
          lk_m1  <= byte_write_sel_n;
          lk_wr  <= 1'b1;
          lk_rd  <= 1'b0;
          lk_tog <= ~lk_tog;
          lk_st  <= DSIO_IDLE;
        end
        default: lk_st <= DSIO_IDLE;
      endcase
    end
  end

  // toggle crossing into the core domain; payload stays stable until the next command is decoded
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else if (clk_en) begin
      s1 <= lk_tog;
      s2 <= s1;
      s3 <= s2;
    end
  end
  wire evt = s2 ^ s3;

  // storage and per-byte merge
  logic [DATA_W-1:0] mem [`DSIO_MEM_DEPTH];
  wire [`DSIO_ADDR_W-1:0] a1 = lk_addr + `DSIO_ADDR_W'(1);
  wire [DATA_W-1:0] old0 = mem[lk_addr];
  wire [DATA_W-1:0] old1 = mem[a1];
  logic [DATA_W-1:0] new0;
  logic [DATA_W-1:0] new1;

  genvar g;
  generate
    for (g = 0; g < NB; g++) begin : g_byte
      // [R08] [R09] [R10] byte gating per beat
      assign new0[g*BW+:BW] = lk_m0[g] ? old0[g*BW+:BW] : lk_d0[g*BW+:BW];
      assign new1[g*BW+:BW] = lk_m1[g] ? old1[g*BW+:BW] : lk_d1[g*BW+:BW];
    end
  endgenerate

  // read burst source and buffer in front of the pins
  dsio_buf_if bif ();
  dsio_rd_e rd_st;
  logic [`DSIO_ADDR_W-1:0] rd_a;

  dsio_skid_buf u_buf (
    .sys_clk (sys_clk),
    .srst    (srst),
    .clk_en  (clk_en),
    .bus     (bif.store)
  );

  assign bif.in_valid = (rd_st != DSIO_RD_IDLE);
  // [R05] burst word address
  assign bif.in_data  = mem[rd_a];

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_st <= DSIO_RD_IDLE;
      rd_a  <= '0;
    end else if (clk_en) begin
      case (rd_st)
        DSIO_RD_IDLE: begin
          if (evt && lk_wr) begin
            // [R05] two-word write burst
            mem[lk_addr] <= new0;
            mem[a1]      <= new1;
          end else if (evt && lk_rd) begin
            rd_a  <= lk_rd_addr;
            rd_st <= DSIO_RD_B0;
          end
        end
        DSIO_RD_B0:
          if (bif.in_ready) begin
            rd_a  <= rd_a + `DSIO_ADDR_W'(1);
            rd_st <= DSIO_RD_B1;
          end
        DSIO_RD_B1:
          if (bif.in_ready)
            rd_st <= DSIO_RD_IDLE;
        default: rd_st <= DSIO_RD_IDLE;
      endcase
    end
  end

  // pin drive: outputs only change on a core edge, so stopped clocks hold them
  assign bif.out_ready = 1'b1;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      // [R03] deselected after reset
      rd_data      <= DATA_W'(`DSIO_DQ_RST);
      rd_data_oe_n <= 1'b1;
    end else if (clk_en) begin
      // [R04] [R06] launch or release on clock edge
      if (bif.out_valid) begin
        rd_data      <= bif.out_data;
        rd_data_oe_n <= 1'b0;
      end else begin
        rd_data_oe_n <= 1'b1;
      end
    end
  end

  // [R03] no drive without data
  property p_idle_hiz;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && !bif.out_valid) |=> rd_data_oe_n;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz) else $error("outputs driven without data"); // [R03]

  // [R02] burst gives two words
  property p_two_words;
    @(posedge sys_clk) disable iff (srst)
      (rd_st == DSIO_RD_B0 && bif.in_ready && clk_en) |=> (rd_st == DSIO_RD_B1);
  endproperty
  a_two_words: assert property (p_two_words) else $error("second read word missing"); // [R02]

  // [R05] second address is first plus one
  property p_next_addr;
    @(posedge sys_clk) disable iff (srst)
      (rd_st == DSIO_RD_B0 && bif.in_ready && clk_en)
        |=> (rd_a == $past(rd_a) + `DSIO_ADDR_W'(1));
  endproperty
  a_next_addr: assert property (p_next_addr) else $error("burst address not sequential"); // [R05]

  // [R04] output holds while clock enable is low
  property p_hold;
    @(posedge sys_clk) disable iff (srst)
      !clk_en |=> $stable(rd_data) && $stable(rd_data_oe_n);
  endproperty
  a_hold: assert property (p_hold) else $error("outputs moved while frozen"); // [R04]

  // [R06] data driven once buffer holds a word
  property p_launch;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && bif.out_valid) |=> (!rd_data_oe_n && rd_data == $past(bif.out_data));
  endproperty
  a_launch: assert property (p_launch) else $error("read word not launched"); // [R06]

  // [R09] [R08] [R10] all beat 0 selects high keeps the first word
  property p_mask_keep;
    @(posedge sys_clk) disable iff (srst)
      (&lk_m0) |-> (new0 == old0);
  endproperty
  a_mask_keep: assert property (p_mask_keep) else $error("masked beat altered word"); // [R09]

  // [R11] beat 1 merge uses beat 1 selects
  property p_beat_sel;
    @(posedge sys_clk) disable iff (srst)
      (lk_m1 == '0) |-> (new1 == lk_d1);
  endproperty
  a_beat_sel: assert property (p_beat_sel) else $error("beat selects misapplied"); // [R11]

  // [R01] write never starts a read burst
  property p_wr_no_rd;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && evt && lk_wr && rd_st == DSIO_RD_IDLE) |=> (rd_st == DSIO_RD_IDLE);
  endproperty
  a_wr_no_rd: assert property (p_wr_no_rd) else $error("write started read"); // [R01]

  // [R03] reset deselects the pins
  property p_rst_quiet;
    @(posedge sys_clk)
      srst |=> (rd_data_oe_n && rd_data == DATA_W'(`DSIO_DQ_RST));
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("reset left pins driven"); // [R03]

  // [R05] burst starts at latched address
  property p_burst_start;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && evt && lk_rd && !lk_wr && rd_st == DSIO_RD_IDLE)
        |=> (rd_st == DSIO_RD_B0 && rd_a == $past(lk_rd_addr));
  endproperty
  a_burst_start: assert property (p_burst_start) else $error("burst not started"); // [R05]

  // [R02] burst ends after two words
  property p_rd_end;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && rd_st == DSIO_RD_B1 && bif.in_ready) |=> (rd_st == DSIO_RD_IDLE);
  endproperty
  a_rd_end: assert property (p_rd_end) else $error("read burst overran"); // [R02]

  // [R05] both burst words land
  property p_wr_land;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && evt && lk_wr && rd_st == DSIO_RD_IDLE)
        |=> (mem[$past(lk_addr)] == $past(new0) && mem[$past(a1)] == $past(new1));
  endproperty
  a_wr_land: assert property (p_wr_land) else $error("write burst not stored"); // [R05]

  // [R01] beat 1 follows beat 0
  property p_beat_order;
    @(posedge link_clk) disable iff (lk_rst)
      (lk_en && lk_st == DSIO_WR_B0) |=> (lk_st == DSIO_WR_B1);
  endproperty
  a_beat_order: assert property (p_beat_order) else $error("write beats out of order"); // [R01]

  // [R06] second beat posts the write
  property p_wr_post;
    @(posedge link_clk) disable iff (lk_rst)
      (lk_en && lk_st == DSIO_WR_B1)
        |=> (lk_wr && !lk_rd && lk_st == DSIO_IDLE && lk_tog != $past(lk_tog));
  endproperty
  a_wr_post: assert property (p_wr_post) else $error("write not handed to core"); // [R06]

  // [R03] load high starts nothing
  property p_nop;
    @(posedge link_clk) disable iff (lk_rst)
      (lk_en && lk_st == DSIO_IDLE && access_load_n)
        |=> (lk_st == DSIO_IDLE && $stable(lk_tog));
  endproperty
  a_nop: assert property (p_nop) else $error("access started with load high"); // [R03]
endmodule

// >>> bench/dsio_ctrl_model.sv
`timescale 1ns/10ps
`include "dsio_defines.svh"
module dsio_ctrl_model #(
  parameter int DATA_W = `DSIO_DATA_W
)(
  // link side controls
  output logic                           link_clk,
  output logic                           access_load_n,
  output logic                           rd_wr_sel,
  output logic [`DSIO_ADDR_W-1:0]        addr,
  output logic [DATA_W-1:0]              wr_data,
  output logic [DATA_W/`DSIO_BYTE_W-1:0] byte_write_sel_n
);
  initial begin
    link_clk = 1'b1;
    access_load_n = 1'b1;
    rd_wr_sel = 1'b1;
    addr = '0;
    wr_data = '0;
    byte_write_sel_n = '1;
  end
  task automatic ticks(input int n);
    repeat (n) begin
      #24 link_clk = 1'b0;
      #24 link_clk = 1'b1;
    end
  endtask
  task automatic access(input logic rd, input logic [`DSIO_ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d0, d1,
                        input logic [DATA_W/`DSIO_BYTE_W-1:0] s0, s1);
    #24 link_clk = 1'b0;
    access_load_n = 1'b0;
    rd_wr_sel = rd;
    addr = a;
    #24 link_clk = 1'b1;
    #24 link_clk = 1'b0;
    access_load_n = 1'b1;
    addr = ~a;
    wr_data = d0;
    byte_write_sel_n = s0;
    #24 link_clk = 1'b1;
    #24 link_clk = 1'b0;
    wr_data = d1;
    byte_write_sel_n = s1;
    #24 link_clk = 1'b1;
    #24 link_clk = 1'b0;
    // released lines show garbage, not the last beat
    wr_data = ~d1;
    byte_write_sel_n = '1;
    rd_wr_sel = ~rd;
    #24 link_clk = 1'b1;
    ticks(2);
  endtask
endmodule

// >>> bench/tb_ddr2_sio_sram_port_protocol.sv
`timescale 1ns/10ps
`include "dsio_defines.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %0t ns: got %h expected %h", $time, (g), (e)); end end
module tb_ddr2_sio_sram_port_protocol
  import dsio_pkg::*;
;
  localparam int DW = 36;
  localparam int NB = DW / `DSIO_BYTE_W;
  logic                    sys_clk, srst, clk_en, link_clk;
  logic                    access_load_n, rd_wr_sel, rd_data_oe_n;
  logic [`DSIO_ADDR_W-1:0] addr;
  logic [DW-1:0]           wr_data, rd_data;
  logic [NB-1:0]           byte_write_sel_n;
  logic [DW-1:0]           exp_mem [`DSIO_MEM_DEPTH];
  logic [DW-1:0]           rx_q [$];
  int                      n_errors = 0, samples_checked = 0, cycles = 0;

  dsio_sram_port #(.DATA_W(DW)) i_dut (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
    .link_clk(link_clk), .access_load_n(access_load_n), .rd_wr_sel(rd_wr_sel),
    .addr(addr), .wr_data(wr_data), .byte_write_sel_n(byte_write_sel_n),
    .rd_data(rd_data), .rd_data_oe_n(rd_data_oe_n));
  dsio_ctrl_model #(.DATA_W(DW)) i_ctrl (.link_clk(link_clk),
    .access_load_n(access_load_n), .rd_wr_sel(rd_wr_sel), .addr(addr),
    .wr_data(wr_data), .byte_write_sel_n(byte_write_sel_n));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // words leave one per cycle; sampled mid-cycle where the registered pins have settled
  always @(negedge sys_clk) begin
    cycles <= cycles + 1;
    if (rd_data_oe_n === 1'b0) rx_q.push_back(rd_data);
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, nw,
                                          input logic [NB-1:0] sel_n);
    merge = old;
    for (int b = 0; b < NB; b++)
      if (!sel_n[b]) merge[b*`DSIO_BYTE_W +: `DSIO_BYTE_W] = nw[b*`DSIO_BYTE_W +: `DSIO_BYTE_W];
  endfunction

  task automatic wr(input logic [7:0] a, input logic [DW-1:0] d0, d1,
                    input logic [NB-1:0] s0, s1);
    i_ctrl.access(1'b0, a, d0, d1, s0, s1);
    exp_mem[a] = merge(exp_mem[a], d0, s0);
    exp_mem[a+8'h01] = merge(exp_mem[a+8'h01], d1, s1);
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic rd_chk(input logic [7:0] a);
    rx_q.delete();
    i_ctrl.access(1'b1, a, 36'h0, 36'h0, 4'hF, 4'hF);
    repeat (12) @(negedge sys_clk);
    `CHK(rx_q.size(), 2)
    if (rx_q.size() == 2) begin
      `CHK(rx_q[0], exp_mem[a])
      `CHK(rx_q[1], exp_mem[a+8'h01])
    end
  endtask

  task automatic t_reset();
    `CHK(rd_data_oe_n, 1'b1)
    `CHK(rd_data, 36'h0)
  endtask
  task automatic t_full();
    wr(8'h10, 36'hA5A5A5A5A, 36'h123456789, 4'h0, 4'h0);
    rd_chk(8'h10);
    wr(8'hFE, 36'hFEDCBA987, 36'h0F0F0F0F0, 4'h0, 4'h0);
    rd_chk(8'hFE);
    `CHK(rx_q.size(), 2)
  endtask
  task automatic t_bytes();
    for (int i = 0; i < NB; i++) begin
      wr(8'h10, 36'h111111111 * (i + 1), 36'hEEEEEEEEE - i, ~(4'h1 << i), ~(4'h8 >> i));
      rd_chk(8'h10);
    end
    wr(8'h10, 36'h0, 36'h3C3C3C3C3, 4'hF, 4'h0);
    rd_chk(8'h10);
  endtask
  task automatic t_freeze();
    rx_q.delete();
    fork
      i_ctrl.access(1'b1, 8'h10, 36'h0, 36'h0, 4'hF, 4'hF);
      begin
        do @(negedge sys_clk); while (rd_data_oe_n !== 1'b0);
        clk_en = 1'b0;
        repeat (5) @(negedge sys_clk);
        `CHK(rd_data_oe_n, 1'b0)
        `CHK(rd_data, exp_mem[8'h10])
        clk_en = 1'b1;
      end
    join
    repeat (8) @(negedge sys_clk);
    i_ctrl.ticks(2);
    // the held first word is collected once per frozen cycle
    `CHK(rx_q.size(), 7)
    if (rx_q.size() == 7) begin
      `CHK(rx_q[5], exp_mem[8'h10])
      `CHK(rx_q[6], exp_mem[8'h11])
    end
  endtask
  task automatic t_idle();
    rx_q.delete();
    i_ctrl.ticks(4);
    wr(8'h40, 36'h055555555, 36'h0AAAAAAAA, 4'h0, 4'h0);
    repeat (12) @(negedge sys_clk);
    `CHK(rx_q.size(), 0)
    repeat (20) @(negedge sys_clk);
    `CHK(rd_data_oe_n, 1'b1)
    `CHK(rx_q.size(), 0)
  endtask

  task automatic results();
    if (n_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    srst = 1'b1;
    clk_en = 1'b1;
    // link reset passes two link flops, so it needs three link edges in and two out
    fork
      repeat (3) @(negedge sys_clk);
      i_ctrl.ticks(3);
    join
    @(negedge sys_clk);
    srst = 1'b0;
    i_ctrl.ticks(2);
    @(negedge sys_clk);
    t_reset();
    t_full();
    t_bytes();
    t_freeze();
    t_idle();
    results();
  end
endmodule
